// ===== psram_host.sv
// Controller end: resets the memory, then runs split read transactions
// Function
// - Start transactions with clock low, complement high
// - Raise select between any two transactions
// - Memory drives strobe for whole read
// - Strobe flags latency, then marks each byte
// - No extra latency: strobe low during address
// - Extra latency: strobe high, then low before data
// - Latency count fits part and clock rate
// - Keep recovery and command spacing between transactions
// - Low-voltage variant gets complementary clock pair
// - No transactions during power-up initialisation time
// - Wait reset-to-select time before selecting
// - Never exceed maximum select low time
// - Hold select extra clocks after last byte
`timescale 1ns/100ps
module psram_host (
  // Clock, reset, enable
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST_N,
  input  wire logic                          CE,
  // Link
  psram_link_if.host                         LINK,
  // Read request
  input  wire logic                          REQ,
  input  wire logic [psram_pkg::ADDR_W-1:0]  REQ_ADDR,
  input  wire logic [7:0]                    REQ_LEN,
  // Status and read data
  output logic                               READY,
  output logic                               BUSY,
  output logic      [psram_pkg::DQ_W-1:0]    RD_DATA,
  output logic                               RD_VALID,
  output logic                               DONE,
  output logic                               TIMEOUT
);
  typedef enum logic [2:0] {S_RST, S_INIT, S_IDLE, S_CA, S_DATA, S_TAIL, S_RECOV} hstate_t;

  hstate_t                      st_q, st_d;
  logic                         rw1_q, rw2_q, rwp_q;
  logic [psram_pkg::DQ_W-1:0]   dq1_q, dq2_q;
  logic [11:0]                  wt_q, wt_d;
  logic [1:0]                   ph_q, ph_d;
  logic                         ck_q, ck_d, ckc_q, ckc_d, cs_q, cs_d, lr_q, lr_d;
  logic [psram_pkg::DQ_W-1:0]   dq_q, dq_d;
  logic                         dqoe_q, dqoe_d;
  logic [47:0]                  ca_q, ca_d, word;
  logic [2:0]                   idx_q, idx_d;
  logic [psram_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [7:0]                   left_q, left_d;
  logic [3:0]                   chk_q, chk_d;
  logic [6:0]                   low_q, low_d;
  logic [5:0]                   clk_q, clk_d, lim_q, lim_d;
  logic                         arm_q, arm_d, start;
  logic                         rdy_q, rdy_d, busy_q, busy_d, rdv_q, rdv_d;
  logic                         done_q, done_d, to_q, to_d;
  logic [psram_pkg::DQ_W-1:0]   rdd_q, rdd_d;
  logic                         strobe, take;

  // Strobe and data synchronisers; both pass the same two stages so they stay aligned
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rw1_q <= 1'b0;
      rw2_q <= 1'b0;
      rwp_q <= 1'b0;
      dq1_q <= 8'h00;
      dq2_q <= 8'h00;
    end
    else if (CE)
    begin
      rw1_q <= LINK.read_write_strobe;
      rw2_q <= rw1_q;
      rwp_q <= rw2_q;
      dq1_q <= LINK.dq;
      dq2_q <= dq1_q;
    end
  end

  // A byte is taken on each strobe change once a rising change armed capture
  assign strobe = rw2_q ^ rwp_q;
  assign take   = (st_q == S_DATA) && strobe && (arm_q || rw2_q);

  // Sequencer
  always_comb
  begin
    word   = 48'h0000_0000_0000;
    start  = 1'b0;
    st_d   = st_q;
    wt_d   = wt_q;
    ph_d   = 2'h0;
    cs_d   = cs_q;
    lr_d   = lr_q;
    dq_d   = dq_q;
    dqoe_d = dqoe_q;
    ca_d   = ca_q;
    idx_d  = idx_q;
    addr_d = addr_q;
    left_d = left_q;
    chk_d  = chk_q;
    low_d  = low_q;
    clk_d  = clk_q;
    lim_d  = lim_q;
    arm_d  = arm_q;
    rdy_d  = rdy_q;
    busy_d = busy_q;
    rdv_d  = 1'b0;
    rdd_d  = rdd_q;
    done_d = 1'b0;
    to_d   = to_q;
    // Bus clock runs only while selected, half period of two cycles
    if (st_q == S_CA || st_q == S_DATA || st_q == S_TAIL)
    begin
      ph_d  = ph_q + 2'h1;
      low_d = low_q + 7'h01;
    end
    unique case (st_q)
      S_RST:
      begin
        if (wt_q == 12'h000)
        begin
          st_d = S_INIT;
          lr_d = 1'b1;
          wt_d = 12'(psram_pkg::INIT_WAIT_CYC - 1);
        end
        else
        begin
          wt_d = wt_q - 12'h001;
        end
      end
      S_INIT:
      begin
        if (wt_q == 12'h000)
        begin
          st_d  = S_IDLE;
          rdy_d = 1'b1;
        end
        else
        begin
          wt_d = wt_q - 12'h001;
        end
      end
      S_IDLE:
      begin
        if (REQ && REQ_LEN != 8'h00)
        begin
          addr_d = REQ_ADDR;
          left_d = REQ_LEN;
          to_d   = 1'b0;
          busy_d = 1'b1;
          start  = 1'b1;
        end
      end
      S_CA:
      begin
        // Bytes change one cycle before each clock edge
        if (ph_d[0])
        begin
          if (idx_q == 3'(psram_pkg::CA_BYTES))
          begin
            st_d   = S_DATA;
            dqoe_d = 1'b0;
            clk_d  = 6'h00;
            arm_d  = 1'b0;
            lim_d  = (rw2_q ? 6'(2 * psram_pkg::INIT_LATENCY) : 6'(psram_pkg::INIT_LATENCY))
                     + 6'(psram_pkg::CHUNK_BYTES / 2 + 2);
          end
          else
          begin
            dq_d  = ca_q[47:40];
            ca_d  = {ca_q[39:0], 8'h00};
            idx_d = idx_q + 3'h1;
          end
        end
      end
      S_DATA:
      begin
        if (ph_d == 2'h2)
        begin
          clk_d = clk_q + 6'h01;
        end
        if (take)
        begin
          arm_d  = 1'b1;
          rdv_d  = 1'b1;
          rdd_d  = dq2_q;
          addr_d = addr_q + 32'h0000_0001;
          left_d = left_q - 8'h01;
          chk_d  = chk_q - 4'h1;
        end
        if (take && chk_q == 4'h1)
        begin
          st_d = S_TAIL;
          wt_d = 12'(psram_pkg::TAIL_CYC);
        end
        else if (clk_q == lim_q || low_q == 7'(psram_pkg::SELECT_GUARD_CYC))
        begin
          // Missing strobes or select time running out: end early
          st_d = S_TAIL;
          wt_d = 12'(psram_pkg::TAIL_CYC);
          to_d = 1'b1;
        end
      end
      S_TAIL:
      begin
        if (wt_q != 12'h000)
        begin
          wt_d = wt_q - 12'h001;
        end
        else if (ph_d == 2'h0)
        begin
          // Deselect with the clock low, then recover
          ph_d = 2'h0;
          cs_d = 1'b1;
          st_d = S_RECOV;
          wt_d = 12'(psram_pkg::RECOV_CYC - 1);
        end
      end
      S_RECOV:
      begin
        if (wt_q != 12'h000)
        begin
          wt_d = wt_q - 12'h001;
        end
        else if (!to_q && left_q != 8'h00)
        begin
          start = 1'b1;
        end
        else
        begin
          st_d   = S_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
    endcase
    // Open one piece: select with clock low and the first command byte
    if (start)
    begin
      word   = {1'b1, 15'h0000, addr_d};
      st_d   = S_CA;
      cs_d   = 1'b0;
      ph_d   = 2'h1;
      dq_d   = word[47:40];
      dqoe_d = 1'b1;
      ca_d   = {word[39:0], 8'h00};
      idx_d  = 3'h1;
      low_d  = 7'h00;
      chk_d  = (left_d > 8'(psram_pkg::CHUNK_BYTES)) ? 4'(psram_pkg::CHUNK_BYTES)
                                                     : left_d[3:0];
    end
    ck_d  = ph_d[1];
    ckc_d = psram_pkg::DIFF_CLK ? ~ph_d[1] : 1'b0;
  end

  // State registers
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q   <= S_RST;
      wt_q   <= 12'(psram_pkg::RP_CYC - 1);
      ph_q   <= 2'h0;
      ck_q   <= 1'b0;
      ckc_q  <= psram_pkg::DIFF_CLK;
      cs_q   <= 1'b1;
      lr_q   <= 1'b0;
      dq_q   <= 8'h00;
      dqoe_q <= 1'b0;
      ca_q   <= 48'h0000_0000_0000;
      idx_q  <= 3'h0;
      addr_q <= 32'h0000_0000;
      left_q <= 8'h00;
      chk_q  <= 4'h0;
      low_q  <= 7'h00;
      clk_q  <= 6'h00;
      lim_q  <= 6'h00;
      arm_q  <= 1'b0;
      rdy_q  <= 1'b0;
      busy_q <= 1'b0;
      rdv_q  <= 1'b0;
      rdd_q  <= 8'h00;
      done_q <= 1'b0;
      to_q   <= 1'b0;
    end
    else if (CE)
    begin
      st_q   <= st_d;
      wt_q   <= wt_d;
      ph_q   <= ph_d;
      ck_q   <= ck_d;
      ckc_q  <= ckc_d;
      cs_q   <= cs_d;
      lr_q   <= lr_d;
      dq_q   <= dq_d;
      dqoe_q <= dqoe_d;
      ca_q   <= ca_d;
      idx_q  <= idx_d;
      addr_q <= addr_d;
      left_q <= left_d;
      chk_q  <= chk_d;
      low_q  <= low_d;
      clk_q  <= clk_d;
      lim_q  <= lim_d;
      arm_q  <= arm_d;
      rdy_q  <= rdy_d;
      busy_q <= busy_d;
      rdv_q  <= rdv_d;
      rdd_q  <= rdd_d;
      done_q <= done_d;
      to_q   <= to_d;
    end
  end

  // Outputs straight from flops
  assign LINK.ck_t    = ck_q;
  assign LINK.ck_c    = ckc_q;
  assign LINK.cs_n    = cs_q;
  assign LINK.rst_n   = lr_q;
  assign LINK.dq_h    = dq_q;
  assign LINK.dq_h_oe = dqoe_q;
  assign READY        = rdy_q;
  assign BUSY         = busy_q;
  assign RD_DATA      = rdd_q;
  assign RD_VALID     = rdv_q;
  assign DONE         = done_q;
  assign TIMEOUT      = to_q;
endmodule // psram_host

// ===== psram_pkg.sv
// Shared constants for the pseudo-static DRAM read link, both ends
package psram_pkg;
  // Local clock
  localparam int SYS_CLK_NS = 40;
  // Link widths
  localparam int DQ_W = 8;
  localparam int ADDR_W = 32;
  localparam int CA_BYTES = 6;
  // Initial latency in bus clocks; set to the part and clock rate in use
  localparam int INIT_LATENCY = 3;
  // Low-voltage variant uses a complementary bus clock
  localparam logic DIFF_CLK = 1'b1;
  // Longest read piece in one select, in bytes
  localparam int CHUNK_BYTES = 8;
  // Cycles of tail clocking after the last wanted byte
  localparam int TAIL_CYC = 4;
  // Link timing figures
  localparam int RESET_PULSE_NS = 200;
  localparam int RESET_TO_SELECT_NS = 400;
  localparam int POWERUP_INIT_US = 150;
  localparam int SELECT_MAX_LOW_NS = 4000;
  localparam int READ_WRITE_RECOVERY_NS = 40;
  localparam int COMMAND_SPACING_NS = 40;
  // Derived cycle counts: least times round up, longest rounds down
  localparam int RP_CYC = (RESET_PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int RPH_CYC = (RESET_TO_SELECT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int VCS_CYC = (POWERUP_INIT_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int INIT_WAIT_CYC = (VCS_CYC > RPH_CYC - RP_CYC) ? VCS_CYC : RPH_CYC - RP_CYC;
  localparam int CSM_CYC = SELECT_MAX_LOW_NS / SYS_CLK_NS;
  localparam int SELECT_GUARD_CYC = CSM_CYC - 2 * TAIL_CYC;
  localparam int RWR_CYC = (READ_WRITE_RECOVERY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int CMS_CYC = (COMMAND_SPACING_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int RECOV_CYC = (RWR_CYC > CMS_CYC) ? RWR_CYC : CMS_CYC;
endpackage

// ===== psram_link_if.sv
// Link wires between the memory controller end and the memory end
`timescale 1ns/100ps
interface psram_link_if;
  logic                        ck_t;
  logic                        ck_c;
  logic                        cs_n;
  logic                        rst_n;
  logic [psram_pkg::DQ_W-1:0]  dq_h;
  logic                        dq_h_oe;
  logic [psram_pkg::DQ_W-1:0]  dq_d;
  logic                        dq_d_oe;
  logic                        read_write_strobe_d;
  logic                        read_write_strobe_d_oe;
  logic [psram_pkg::DQ_W-1:0]  dq;
  logic                        read_write_strobe;

  // Wire levels; an undriven wire reads low
  assign dq   = dq_h_oe ? dq_h : (dq_d_oe ? dq_d : 8'h00);
  assign read_write_strobe = read_write_strobe_d_oe & read_write_strobe_d;

  modport host (output ck_t, ck_c, cs_n, rst_n, dq_h, dq_h_oe, input dq, read_write_strobe);
  modport device (input ck_t, ck_c, cs_n, rst_n, dq, output dq_d, dq_d_oe, read_write_strobe_d, read_write_strobe_d_oe);
endinterface // psram_link_if

// ===== psram_dev.sv
// Memory end: answers read transactions with strobed double-rate data
`timescale 1ns/100ps
module psram_dev (
  // Clock, reset, enable
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST_N,
  input  wire logic                          CE,
  // Link
  psram_link_if.device                       LINK,
  // User side
  input  wire logic                          REFRESH_PENDING,
  input  wire logic [psram_pkg::DQ_W-1:0]    RD_DATA,
  output logic      [psram_pkg::ADDR_W-1:0]  RD_ADDR,
  output logic                               RD_TAKEN,
  output logic                               SELECTED,
  output logic                               EXTRA_USED
);
  typedef enum logic [2:0] {S_IDLE, S_CA, S_LAT, S_DATA, S_SKIP} dstate_t;

  dstate_t                      st_q, st_d;
  logic                         ck1_q, ck2_q, ckp_q, cs1_q, cs2_q, lr1_q, lr2_q;
  logic [psram_pkg::DQ_W-1:0]   dq1_q, dq2_q;
  logic [2:0]                   cnt_q, cnt_d;
  logic [3:0]                   lat_q, lat_d;
  logic [47:0]                  ca_q, ca_d;
  logic [psram_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [psram_pkg::DQ_W-1:0]   dq_q, dq_d;
  logic                         dqoe_q, dqoe_d, rw_q, rw_d, rwoe_q, rwoe_d;
  logic                         tk_q, tk_d, sel_q, sel_d, ex_q, ex_d;
  logic                         rise, fall;

  // Pin synchronisers; the complement clock is not needed, edges come from the true clock
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ck1_q <= 1'b0;
      ck2_q <= 1'b0;
      ckp_q <= 1'b0;
      cs1_q <= 1'b1;
      cs2_q <= 1'b1;
      lr1_q <= 1'b0;
      lr2_q <= 1'b0;
      dq1_q <= 8'h00;
      dq2_q <= 8'h00;
    end
    else if (CE)
    begin
      ck1_q <= LINK.ck_t;
      ck2_q <= ck1_q;
      ckp_q <= ck2_q;
      cs1_q <= LINK.cs_n;
      cs2_q <= cs1_q;
      lr1_q <= LINK.rst_n;
      lr2_q <= lr1_q;
      dq1_q <= LINK.dq;
      dq2_q <= dq1_q;
    end
  end

  // Edges of the synchronised bus clock
  assign rise = ck2_q & ~ckp_q;
  assign fall = ~ck2_q & ckp_q;

  // Transaction sequencer
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    lat_d  = lat_q;
    ca_d   = ca_q;
    addr_d = addr_q;
    dq_d   = dq_q;
    dqoe_d = dqoe_q;
    rw_d   = rw_q;
    rwoe_d = rwoe_q;
    tk_d   = 1'b0;
    sel_d  = ~cs2_q;
    ex_d   = ex_q;
    if (!lr2_q || cs2_q)
    begin
      // Deselect or link reset releases both lines at once
      st_d   = S_IDLE;
      dqoe_d = 1'b0;
      rwoe_d = 1'b0;
      rw_d   = 1'b0;
    end
    else
    begin
      unique case (st_q)
        S_IDLE:
        begin
          st_d   = S_CA;
          cnt_d  = 3'h0;
          ex_d   = REFRESH_PENDING;
          rwoe_d = 1'b1;
          rw_d   = REFRESH_PENDING;
        end
        S_CA:
        begin
          if (rise || fall)
          begin
            ca_d  = {ca_q[39:0], dq2_q};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'(psram_pkg::CA_BYTES - 1))
            begin
              if (ca_q[39])
              begin
                // Read: strobe goes low before any data
                st_d   = S_LAT;
                rw_d   = 1'b0;
                addr_d = {ca_q[23:0], dq2_q};
                lat_d  = ex_q ? 4'(2 * psram_pkg::INIT_LATENCY)
                              : 4'(psram_pkg::INIT_LATENCY);
              end
              else
              begin
                // Writes are not served here; release the strobe
                st_d   = S_SKIP;
                rwoe_d = 1'b0;
              end
            end
          end
        end
        S_LAT:
        begin
          if (rise)
          begin
            if (lat_q == 4'h1)
            begin
              st_d   = S_DATA;
              dqoe_d = 1'b1;
              dq_d   = RD_DATA;
              rw_d   = 1'b1;
              addr_d = addr_q + 32'h0000_0001;
              tk_d   = 1'b1;
            end
            else
            begin
              lat_d = lat_q - 4'h1;
            end
          end
        end
        S_DATA:
        begin
          // One byte per bus clock edge, strobe follows the clock
          if (rise || fall)
          begin
            dq_d   = RD_DATA;
            rw_d   = rise;
            addr_d = addr_q + 32'h0000_0001;
            tk_d   = 1'b1;
          end
        end
        S_SKIP:
        begin
          st_d = S_SKIP;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q   <= S_IDLE;
      cnt_q  <= 3'h0;
      lat_q  <= 4'h0;
      ca_q   <= 48'h0000_0000_0000;
      addr_q <= 32'h0000_0000;
      dq_q   <= 8'h00;
      dqoe_q <= 1'b0;
      rw_q   <= 1'b0;
      rwoe_q <= 1'b0;
      tk_q   <= 1'b0;
      sel_q  <= 1'b0;
      ex_q   <= 1'b0;
    end
    else if (CE)
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      lat_q  <= lat_d;
      ca_q   <= ca_d;
      addr_q <= addr_d;
      dq_q   <= dq_d;
      dqoe_q <= dqoe_d;
      rw_q   <= rw_d;
      rwoe_q <= rwoe_d;
      tk_q   <= tk_d;
      sel_q  <= sel_d;
      ex_q   <= ex_d;
    end
  end

  // Outputs straight from flops
  assign LINK.dq_d      = dq_q;
  assign LINK.dq_d_oe   = dqoe_q;
  assign LINK.read_write_strobe_d    = rw_q;
  assign LINK.read_write_strobe_d_oe = rwoe_q;
  assign RD_ADDR        = addr_q;
  assign RD_TAKEN       = tk_q;
  assign SELECTED       = sel_q;
  assign EXTRA_USED     = ex_q;
endmodule // psram_dev

// ===== psram_link_sva.sv
// Link timing checks between the controller end and the memory end
`timescale 1ns/100ps
module psram_link_sva (
  // Clock and reset
  input  wire logic  SYS_CLK,
  input  wire logic  RST_N,
  // Link wires
  input  wire logic  ck_t,
  input  wire logic  ck_c,
  input  wire logic  cs_n,
  input  wire logic  rst_n,
  input  wire logic  dq_h_oe,
  input  wire logic  dq_d_oe,
  input  wire logic  read_write_strobe_d_oe,
  input  wire logic  read_write_strobe
);
  localparam int LAT      = psram_pkg::INIT_LATENCY;
  localparam int CA_RISES = psram_pkg::CA_BYTES / 2;
  localparam int RECOV    = psram_pkg::RECOV_CYC;
  localparam int CSM      = psram_pkg::CSM_CYC;
  localparam int VCS      = psram_pkg::VCS_CYC;

  logic [11:0]  rst_cnt_q, rst_cnt_d;
  logic [7:0]   lo_cnt_q, lo_cnt_d, rise_cnt_q, rise_cnt_d;
  logic [3:0]   hi_cnt_q, hi_cnt_d;
  logic         ck_prev_q, extra_q, extra_d, seen_q, seen_d;

  // Counters; the strobe flag is only trusted once an earlier piece has surely let go
  always_comb
  begin
    rst_cnt_d  = (!rst_n) ? 12'h000 : rst_cnt_q + {11'h000, rst_cnt_q != 12'hfff};
    hi_cnt_d   = cs_n ? hi_cnt_q + {3'h0, hi_cnt_q != 4'hf} : 4'h0;
    lo_cnt_d   = cs_n ? 8'h00 : lo_cnt_q + {7'h00, lo_cnt_q != 8'hff};
    rise_cnt_d = cs_n ? 8'h00 : rise_cnt_q + {7'h00, ck_t & ~ck_prev_q};
    extra_d    = !cs_n && (extra_q || (dq_h_oe && read_write_strobe && lo_cnt_q > 8'h05));
    seen_d     = !cs_n && (seen_q || (dq_d_oe && read_write_strobe && lo_cnt_q > 8'h08));
  end

  // Register the helper state
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_cnt_q  <= 12'h000;
      hi_cnt_q   <= 4'h0;
      lo_cnt_q   <= 8'h00;
      rise_cnt_q <= 8'h00;
      ck_prev_q  <= 1'h0;
      extra_q    <= 1'h0;
      seen_q     <= 1'h0;
    end
    else
    begin
      rst_cnt_q  <= rst_cnt_d;
      hi_cnt_q   <= hi_cnt_d;
      lo_cnt_q   <= lo_cnt_d;
      rise_cnt_q <= rise_cnt_d;
      ck_prev_q  <= ck_t;
      extra_q    <= extra_d;
      seen_q     <= seen_d;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_select_clock_low: assert property (
    $fell(cs_n) |-> !ck_t && ck_c == psram_pkg::DIFF_CLK) else $error("select with clock high");
  a_recovery_gap: assert property (
    $fell(cs_n) |-> hi_cnt_q >= RECOV) else $error("select high too short");
  a_strobe_start: assert property (
    $fell(cs_n) |-> ##[1:4] read_write_strobe_d_oe) else $error("strobe not driven after select");
  a_strobe_hold: assert property (
    read_write_strobe_d_oe && !cs_n && lo_cnt_q > 8'h04 |=> read_write_strobe_d_oe)
    else $error("strobe released while selected");
  a_release_deselect: assert property (
    $rose(cs_n) |-> ##[1:4] (!read_write_strobe_d_oe && !dq_d_oe)) else $error("link not released");
  a_strobe_rise_owner: assert property (
    $rose(read_write_strobe) |-> dq_h_oe || dq_d_oe) else $error("strobe rose outside flag or data");
  a_first_data_latency: assert property (
    !cs_n && dq_d_oe && read_write_strobe && !seen_q && lo_cnt_q > 8'h08
    |-> rise_cnt_q == (extra_q ? CA_RISES + 2 * LAT : CA_RISES + LAT))
    else $error("first data at wrong latency");
  a_select_max_low: assert property (
    lo_cnt_q <= CSM) else $error("select held low too long");
  a_init_wait: assert property (
    $fell(cs_n) |-> rst_cnt_q >= VCS) else $error("select during initialisation");
  a_clock_pair: assert property (
    ck_c == (psram_pkg::DIFF_CLK ? ~ck_t : 1'h0)) else $error("complement clock wrong");
endmodule // psram_link_sva

// ===== tb_psram_ddr_read_signalling.sv
// Self-checking bench: controller end reading from the memory end over the link
`timescale 1ns/100ps
`define CHECK(a, b, m) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb_psram_ddr_read_signalling;
  logic                             sys_clk, rst_n, req, ready, busy, rd_valid, done, timeout;
  logic [31:0]                      req_addr, a, r;
  logic [7:0]                       req_len, rd_data_h, rd_data_d;
  logic                             refresh, rd_taken, selected, extra_used, cs_prev;
  logic [psram_pkg::ADDR_W-1:0]     rd_addr;
  logic [7:0]                       exp_q[$];
  int                               n_fail, n_tests, n_sel, n_tk, seed, i, k;

  // Byte pattern served by the memory for each address
  function automatic logic [7:0] data_of(input logic [31:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'ha5;
  endfunction

  psram_link_if link ();
  psram_host i_psram_host (.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(1'h1), .LINK(link),
    .REQ(req), .REQ_ADDR(req_addr), .REQ_LEN(req_len), .READY(ready), .BUSY(busy),
    .RD_DATA(rd_data_h), .RD_VALID(rd_valid), .DONE(done), .TIMEOUT(timeout));
  psram_dev i_psram_dev (.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(1'h1), .LINK(link),
    .REFRESH_PENDING(refresh), .RD_DATA(rd_data_d), .RD_ADDR(rd_addr),
    .RD_TAKEN(rd_taken), .SELECTED(selected), .EXTRA_USED(extra_used));
  psram_link_sva i_psram_link_sva (.SYS_CLK(sys_clk), .RST_N(rst_n), .ck_t(link.ck_t),
    .ck_c(link.ck_c), .cs_n(link.cs_n), .rst_n(link.rst_n), .dq_h_oe(link.dq_h_oe),
    .dq_d_oe(link.dq_d_oe), .read_write_strobe_d_oe(link.read_write_strobe_d_oe), .read_write_strobe(link.read_write_strobe));

  // Memory answers combinationally for the address it is serving
  assign rd_data_d = data_of(rd_addr);

  // Clock, 40 ns period
  initial
  begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Scoreboard and select counter; bytes must arrive in address order
  always @(negedge sys_clk)
  begin
    if (rd_valid === 1'h1)
    begin
      `CHECK(exp_q.size() > 0, 1'h1, "unexpected byte")
      if (exp_q.size() > 0)
        `CHECK(rd_data_h, exp_q.pop_front(), "byte value")
    end
    if (cs_prev === 1'h1 && link.cs_n === 1'h0)
      n_sel++;
    // Memory side hand-offs; it may serve more than the host keeps
    if (rd_taken === 1'h1)
      n_tk++;
    cs_prev = link.cs_n;
  end

  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One read request; a second request while busy must be ignored
  task automatic run_req(input logic [31:0] ad, input logic [7:0] len, input logic rf);
    int j;
    int lim;
    lim = 130 * ((len + 7) / 8) + 100;
    @(negedge sys_clk);
    refresh = rf;
    repeat (4) @(negedge sys_clk);
    n_sel = 0;
    n_tk = 0;
    req = 1'h1;
    req_addr = ad;
    req_len = len;
    for (j = 0; j < len; j++)
      exp_q.push_back(data_of(ad + j));
    @(negedge sys_clk);
    req = 1'h0;
    repeat (12) @(negedge sys_clk);
    `CHECK(extra_used, rf, "extra latency flag")
    `CHECK(selected, 1'h1, "memory not selected")
    req = 1'h1;
    req_len = 8'h04;
    @(negedge sys_clk);
    req = 1'h0;
    j = 0;
    while (done !== 1'h1 && j < lim)
    begin
      @(negedge sys_clk);
      j++;
    end
    `CHECK(done, 1'h1, "request never completed")
    `CHECK(exp_q.size(), 0, "bytes missing")
    `CHECK(n_sel, (len + 7) / 8, "select count per request")
    `CHECK(timeout, 1'h0, "piece ended early")
    `CHECK(n_tk >= len, 1'h1, "too few bytes served")
    exp_q.delete();
  endtask

  // Watchdog against a hung link
  initial
  begin
    #1600000;
    n_fail++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    seed = 32'h3afb;
    rst_n = 1'h0;
    req = 1'h0;
    req_addr = 32'h0000_0000;
    req_len = 8'h00;
    refresh = 1'h0;
    cs_prev = 1'h1;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'h1;
    // A request during initialisation is ignored
    req = 1'h1;
    req_len = 8'h04;
    @(negedge sys_clk);
    req = 1'h0;
    repeat (20) @(negedge sys_clk);
    `CHECK(busy, 1'h0, "busy during init")
    `CHECK(link.cs_n, 1'h1, "selected during init")
    k = 0;
    while (ready !== 1'h1 && k < 5000)
    begin
      @(negedge sys_clk);
      k++;
    end
    `CHECK(ready, 1'h1, "never ready")
    // Zero length is refused
    req = 1'h1;
    req_len = 8'h00;
    @(negedge sys_clk);
    req = 1'h0;
    repeat (10) @(negedge sys_clk);
    `CHECK(busy, 1'h0, "zero length taken")
    // Corner lengths and address wrap, both latency kinds
    run_req(32'h0000_0100, 8'h01, 1'h0);
    run_req(32'h0000_0200, 8'h08, 1'h1);
    run_req(32'hffff_fffc, 8'h09, 1'h0);
    run_req(32'h1234_5678, 8'hff, 1'h1);
    for (i = 0; i < 10; i++)
    begin
      a = $random(seed);
      r = $random(seed);
      run_req(a, 8'h01 + {3'h0, r[4:0]}, r[8]);
    end
    print_verdict();
  end
endmodule // tb_psram_ddr_read_signalling
